// ==== core/smsc_pkg.sv ====
package smsc_pkg;
    // clock and timing
    localparam int CLK_NS = 10;
    localparam int CLK_HZ = 1_000_000_000 / CLK_NS;
    localparam int RST_PULSE_MIN_NS = 1500;
    localparam int RST_PULSE_MAX_NS = 8000;
    localparam int SLEEP_ENTRY_NS = 40000;
    localparam int RST_PULSE_MIN_CYC = (RST_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_PULSE_MAX_CYC = RST_PULSE_MAX_NS / CLK_NS;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [27:0] STEP_ACC_WRAP = 28'(CLK_HZ);

    // serial word layout: register index on top, data below
    localparam int WORD_BITS = 16;
    localparam int SER_IDX_LSB = 12;

    // register indices, byte address is index times four
    localparam logic [3:0] REG_CFG = 4'h0;
    localparam logic [3:0] REG_STEP = 4'h1;
    localparam logic [3:0] REG_ACC = 4'h2;
    localparam logic [3:0] REG_DEC = 4'h3;
    localparam logic [3:0] REG_SSR = 4'h4;
    localparam logic [3:0] REG_RSR = 4'h5;
    localparam logic [3:0] REG_DIR = 4'h6;
    localparam logic [3:0] REG_NSM = 4'h7;
    localparam logic [3:0] REG_NSL = 4'h8;
    localparam logic [3:0] REG_DIRECTION_READBACK = 4'hD;
    localparam logic [3:0] REG_STAT = 4'hE;

    // field positions
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_DIAGNOSTIC_OUT_LSB = 3;
    localparam int DIRECTION_READBACK_BIT = 0;
    localparam int FAULT_BIT = 1;

    typedef enum logic [2:0] {
        SMSC_MS_FULL, SMSC_MS_HALF, SMSC_MS_QUARTER, SMSC_MS_EIGHTH,
        SMSC_MS_SIXTEENTH, SMSC_MS_FULL_SINGLE
    } smsc_mode_t;
    typedef enum logic [1:0] {
        SMSC_DIAGNOSTIC_OUT_FAULT, SMSC_DIAGNOSTIC_OUT_BUSY, SMSC_DIAGNOSTIC_OUT_DIR, SMSC_DIAGNOSTIC_OUT_STEP
    } smsc_diagnostic_out_t;
    typedef enum logic [1:0] {
        SMSC_SEQ_IDLE, SMSC_SEQ_CALC, SMSC_SEQ_RUN
    } smsc_seq_t;

    // reset values
    localparam smsc_mode_t MODE_RST = SMSC_MS_HALF;
    localparam smsc_diagnostic_out_t DIAGNOSTIC_OUT_RST = SMSC_DIAGNOSTIC_OUT_FAULT;
    localparam logic [5:0] ANGLE_HOME = 6'h08;
    localparam logic [5:0] ANGLE_HOME_SINGLE = 6'h00;

    typedef struct packed {
        logic [5:0] accel;
        logic [5:0] decel;
        logic [5:0] start;
        logic [5:0] run;
        logic dir;
        logic [15:0] count;
    } smsc_prof_t;

    typedef struct packed {
        logic sck;
        logic serial_data_in;
        logic serial_strobe_n;
        logic step;
        logic dir;
        logic rstn;
    } smsc_pins_t;

    typedef struct packed {
        smsc_pins_t sync1;
        smsc_pins_t sync2;
        smsc_pins_t prev;
        logic [15:0] rx_sh;
        logic [4:0] rx_cnt;
        logic [15:0] tx_sh;
        logic serial_data_out;
        logic sdo_oe_n;
        smsc_mode_t mode;
        smsc_diagnostic_out_t diagnostic_out_sel;
        smsc_prof_t shadow;
        smsc_prof_t act;
        logic [5:0] angle;
        logic direction_readback;
        logic op_dir;
        logic fault;
        logic sleep;
        logic [11:0] rst_cnt;
        smsc_seq_t seq;
        logic [15:0] remain;
        logic [15:0] dec_steps;
        logic [6:0] tmp;
        logic [6:0] rate;
        logic [27:0] accum;
        logic step_pulse;
        logic diagnostic_out;
        logic [31:0] prdata;
    } smsc_state_t;

    // microstep increment for pin-driven stepping
    function automatic logic [5:0] smsc_mode_inc(smsc_mode_t m);
        case (m)
            SMSC_MS_FULL: return 6'h10;
            SMSC_MS_FULL_SINGLE: return 6'h10;
            SMSC_MS_HALF: return 6'h08;
            SMSC_MS_QUARTER: return 6'h04;
            SMSC_MS_EIGHTH: return 6'h02;
            default: return 6'h01;
        endcase
    endfunction

    function automatic logic [5:0] smsc_home(smsc_mode_t m);
        return (m == SMSC_MS_FULL_SINGLE) ? ANGLE_HOME_SINGLE : ANGLE_HOME;
    endfunction

    function automatic smsc_state_t smsc_state_rst();
        smsc_state_t s;
        s = '0;
        s.sync1.serial_strobe_n = 1'b1;
        s.sync2.serial_strobe_n = 1'b1;
        s.prev.serial_strobe_n = 1'b1;
        s.sync1.rstn = 1'b1;
        s.sync2.rstn = 1'b1;
        s.prev.rstn = 1'b1;
        s.sync1.sck = 1'b1;
        s.sync2.sck = 1'b1;
        s.prev.sck = 1'b1;
        s.sdo_oe_n = 1'b1;
        s.mode = MODE_RST;
        s.diagnostic_out_sel = DIAGNOSTIC_OUT_RST;
        s.angle = ANGLE_HOME;
        s.seq = SMSC_SEQ_IDLE;
        return s;
    endfunction

    localparam smsc_state_t STATE_RST = smsc_state_rst();
endpackage

// ==== core/smsc_top.sv ====
`timescale 1ns/1ps
module smsc_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic serial_clk_i,
    input wire logic serial_data_in_i,
    input wire logic serial_strobe_n_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_n_o,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic reset_sleep_n_i,
    input wire logic fault_event_i,
    output logic diagnostic_out_o,
    output logic sleep_o,
    output logic [5:0] step_angle_o,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    smsc_pkg::smsc_state_t s_q;
    smsc_pkg::smsc_state_t s_d;
    smsc_pkg::smsc_pins_t pins;
    logic serial_strobe_n_fall;
    logic serial_strobe_n_rise;
    logic sck_rise;
    logic sck_fall;
    logic step_rise;
    logic rstn_rise;
    logic apb_wr;
    logic [27:0] acc_n;
    logic seq_tick;
    logic [6:0] eff_start;

    // register read decode, used by the bus only; the serial status word is built separately
    function automatic logic [11:0] reg_rd(smsc_pkg::smsc_state_t s,
                                           logic [3:0] idx);
        logic [11:0] r;
        r = 12'h000;
        case (idx)
            smsc_pkg::REG_CFG: begin
                r[smsc_pkg::CFG_MODE_LSB +: 3] = s.mode;
                r[smsc_pkg::CFG_DIAGNOSTIC_OUT_LSB +: 2] = s.diagnostic_out_sel;
            end
            smsc_pkg::REG_ACC: r[5:0] = s.shadow.accel;
            smsc_pkg::REG_DEC: r[5:0] = s.shadow.decel;
            smsc_pkg::REG_SSR: r[5:0] = s.shadow.start;
            smsc_pkg::REG_RSR: r[5:0] = s.shadow.run;
            smsc_pkg::REG_DIR: r[0] = s.shadow.dir;
            smsc_pkg::REG_NSM: r[7:0] = s.shadow.count[15:8];
            smsc_pkg::REG_NSL: r[7:0] = s.shadow.count[7:0];
            smsc_pkg::REG_DIRECTION_READBACK: begin
                r[smsc_pkg::DIRECTION_READBACK_BIT] = s.direction_readback;
                r[smsc_pkg::FAULT_BIT] = s.fault;
            end
            smsc_pkg::REG_STAT: begin
                r[5:0] = s.angle;
                r[6] = s.sleep;
                r[7] = (s.seq != smsc_pkg::SMSC_SEQ_IDLE);
                r[8] = s.op_dir;
            end
            default: r = 12'h000;
        endcase
        return r;
    endfunction

    function automatic logic reg_mapped(logic [3:0] idx);
        return (idx <= smsc_pkg::REG_NSL) || (idx == smsc_pkg::REG_DIRECTION_READBACK) ||
               (idx == smsc_pkg::REG_STAT);
    endfunction

    // register write, shared by the serial port and the bus
    function automatic smsc_pkg::smsc_state_t reg_wr(
        smsc_pkg::smsc_state_t s, logic [3:0] idx, logic [11:0] v);
        logic [6:0] st;
        st = 7'h00;
        case (idx)
            smsc_pkg::REG_CFG: begin
                s.mode = smsc_pkg::smsc_mode_t'(v[smsc_pkg::CFG_MODE_LSB +: 3]);
                s.diagnostic_out_sel =
                    smsc_pkg::smsc_diagnostic_out_t'(v[smsc_pkg::CFG_DIAGNOSTIC_OUT_LSB +: 2]);
            end
            smsc_pkg::REG_STEP: begin
                // two's complement add wraps the angle both ways
                if (s.seq == smsc_pkg::SMSC_SEQ_IDLE && !s.sleep &&
                    v[5:0] != 6'h00) begin
                    s.angle = s.angle + v[5:0];
                    s.op_dir = ~v[5];
                    s.step_pulse = 1'b1;
                end
            end
            smsc_pkg::REG_ACC: s.shadow.accel = v[5:0];
            smsc_pkg::REG_DEC: s.shadow.decel = v[5:0];
            smsc_pkg::REG_SSR: s.shadow.start = v[5:0];
            smsc_pkg::REG_RSR: s.shadow.run = v[5:0];
            smsc_pkg::REG_DIR: s.shadow.dir = v[0];
            smsc_pkg::REG_NSM: s.shadow.count[15:8] = v[7:0];
            smsc_pkg::REG_NSL: begin
                s.shadow.count[7:0] = v[7:0];
                s.act = s.shadow;
                s.remain = s.shadow.count;
                st = (s.act.start == 6'h00) ? 7'h01 : {1'b0, s.act.start};
                if (s.shadow.count == 16'h0000 || s.sleep) begin
                    s.seq = smsc_pkg::SMSC_SEQ_IDLE;
                end else begin
                    // from standstill the first step runs at start rate
                    if (s.seq == smsc_pkg::SMSC_SEQ_IDLE) begin
                        s.rate = st;
                        s.accum = 28'h0000000;
                    end
                    s.tmp = ({1'b0, s.act.run} > st) ?
                            ({1'b0, s.act.run} - st) : 7'h00;
                    s.dec_steps = 16'h0000;
                    s.op_dir = s.act.dir;
                    s.seq = smsc_pkg::SMSC_SEQ_CALC;
                end
            end
            default: s = s;
        endcase
        return s;
    endfunction

    assign pins = '{sck: serial_clk_i, serial_data_in: serial_data_in_i,
                    serial_strobe_n: serial_strobe_n_i, step: step_i, dir: dir_i,
                    rstn: reset_sleep_n_i};

    // edges are found on the second synchroniser stage only
    assign serial_strobe_n_fall = s_q.prev.serial_strobe_n & ~s_q.sync2.serial_strobe_n;
    assign serial_strobe_n_rise = ~s_q.prev.serial_strobe_n & s_q.sync2.serial_strobe_n;
    assign sck_rise = ~s_q.prev.sck & s_q.sync2.sck;
    assign sck_fall = s_q.prev.sck & ~s_q.sync2.sck;
    assign step_rise = ~s_q.prev.step & s_q.sync2.step;
    assign rstn_rise = ~s_q.prev.rstn & s_q.sync2.rstn;
    assign apb_wr = psel & penable & pwrite;
    assign acc_n = s_q.accum + 28'({s_q.rate, 4'h0});
    assign seq_tick = (s_q.seq == smsc_pkg::SMSC_SEQ_RUN) &&
                      (acc_n >= smsc_pkg::STEP_ACC_WRAP);
    assign eff_start = (s_q.act.start == 6'h00) ? 7'h01 :
                       {1'b0, s_q.act.start};

    // next-state logic for the whole block
    always_comb begin
        logic clr;
        logic [15:0] rem_n;
        clr = 1'b0;
        rem_n = s_q.remain - 16'h0001;
        s_d = s_q;
        s_d.step_pulse = 1'b0;
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        if (psel && !penable) begin
            s_d.prdata = {20'h00000, reg_rd(s_q, paddr[5:2])};
        end
        // reset pin: measure low time, sleep while held long, clear or wake on release
        if (!s_q.sync2.rstn) begin
            if (s_q.rst_cnt < 12'(smsc_pkg::SLEEP_ENTRY_CYC)) begin
                s_d.rst_cnt = s_q.rst_cnt + 12'h001;
            end else begin
                s_d.sleep = 1'b1;
            end
        end else if (rstn_rise) begin
            if (s_q.sleep) begin
                s_d.angle = smsc_pkg::smsc_home(s_q.mode);
                s_d.seq = smsc_pkg::SMSC_SEQ_IDLE;
            end else if (s_q.rst_cnt >= 12'(smsc_pkg::RST_PULSE_MIN_CYC) &&
                         s_q.rst_cnt <= 12'(smsc_pkg::RST_PULSE_MAX_CYC)) begin
                clr = 1'b1;
            end
            s_d.rst_cnt = 12'h000;
            s_d.sleep = 1'b0;
        end
        // a new fault in the clearing cycle is kept
        s_d.fault = fault_event_i | (s_q.fault & ~clr);
        // serial frame
        if (serial_strobe_n_fall) begin
            s_d.rx_cnt = 5'h00;
            s_d.sdo_oe_n = 1'b0;
            s_d.serial_data_out = s_q.fault;
            s_d.tx_sh = {s_q.op_dir, s_q.seq != smsc_pkg::SMSC_SEQ_IDLE,
                         s_q.sleep, s_q.angle, 7'h00};
            s_d.direction_readback = s_q.op_dir;
        end else if (!s_q.sync2.serial_strobe_n) begin
            if (sck_rise) begin
                s_d.rx_sh = {s_q.rx_sh[14:0], s_q.sync2.serial_data_in};
                if (s_q.rx_cnt <= 5'(smsc_pkg::WORD_BITS)) begin
                    s_d.rx_cnt = s_q.rx_cnt + 5'h01;
                end
            end
            if (sck_fall) begin
                s_d.serial_data_out = s_q.tx_sh[15];
                s_d.tx_sh = {s_q.tx_sh[14:0], 1'b0};
            end
        end
        if (serial_strobe_n_rise) begin
            s_d.sdo_oe_n = 1'b1;
            s_d.serial_data_out = 1'b0;
        end
        // pin-driven stepping, only while no sequence runs
        if (step_rise && s_q.seq == smsc_pkg::SMSC_SEQ_IDLE &&
            !s_q.sleep) begin
            s_d.angle = s_q.sync2.dir ?
                        s_q.angle + smsc_pkg::smsc_mode_inc(s_q.mode) :
                        s_q.angle - smsc_pkg::smsc_mode_inc(s_q.mode);
            s_d.op_dir = s_q.sync2.dir;
            s_d.step_pulse = 1'b1;
        end
        // programmed sequence
        case (s_q.seq)
            smsc_pkg::SMSC_SEQ_IDLE: s_d.accum = s_q.accum;
            smsc_pkg::SMSC_SEQ_CALC: begin
                // count steps needed to slow from run to start rate
                if (s_q.act.decel == 6'h00 || s_q.tmp == 7'h00) begin
                    s_d.seq = smsc_pkg::SMSC_SEQ_RUN;
                end else if (s_q.tmp > {1'b0, s_q.act.decel}) begin
                    s_d.tmp = s_q.tmp - {1'b0, s_q.act.decel};
                    s_d.dec_steps = s_q.dec_steps + 16'h0001;
                end else begin
                    s_d.tmp = 7'h00;
                    s_d.dec_steps = s_q.dec_steps + 16'h0001;
                end
            end
            smsc_pkg::SMSC_SEQ_RUN: begin
                if (seq_tick) begin
                    // one sixteenth per tick keeps travel resolution-free
                    s_d.accum = acc_n - smsc_pkg::STEP_ACC_WRAP;
                    s_d.angle = s_q.act.dir ? s_q.angle + 6'h01 :
                                s_q.angle - 6'h01;
                    s_d.op_dir = s_q.act.dir;
                    s_d.step_pulse = 1'b1;
                    s_d.remain = rem_n;
                    if (rem_n == 16'h0000) begin
                        s_d.seq = smsc_pkg::SMSC_SEQ_IDLE;
                        s_d.accum = 28'h0000000;
                    end else if (rem_n <= s_q.dec_steps) begin
                        s_d.rate = (s_q.rate > eff_start +
                                    {1'b0, s_q.act.decel}) ?
                                   s_q.rate - {1'b0, s_q.act.decel} :
                                   eff_start;
                    end else if (s_q.rate < {1'b0, s_q.act.run}) begin
                        s_d.rate = (s_q.rate + {1'b0, s_q.act.accel} >
                                    {1'b0, s_q.act.run}) ?
                                   {1'b0, s_q.act.run} :
                                   s_q.rate + {1'b0, s_q.act.accel};
                    end
                end else begin
                    s_d.accum = acc_n;
                end
            end
            default: s_d.seq = smsc_pkg::SMSC_SEQ_IDLE;
        endcase
        // register writes after motion so a restart takes priority
        if (apb_wr && paddr[7:6] == 2'h0 && reg_mapped(paddr[5:2])) begin
            s_d = reg_wr(s_d, paddr[5:2], pwdata[11:0]);
        end
        if (serial_strobe_n_rise && s_q.rx_cnt == 5'(smsc_pkg::WORD_BITS)) begin
            s_d = reg_wr(s_d, s_q.rx_sh[15:smsc_pkg::SER_IDX_LSB],
                         s_q.rx_sh[11:0]);
        end
        // diagnostic output source
        case (s_d.diagnostic_out_sel)
            smsc_pkg::SMSC_DIAGNOSTIC_OUT_FAULT: s_d.diagnostic_out = s_d.fault;
            smsc_pkg::SMSC_DIAGNOSTIC_OUT_BUSY:
                s_d.diagnostic_out = (s_d.seq != smsc_pkg::SMSC_SEQ_IDLE);
            smsc_pkg::SMSC_DIAGNOSTIC_OUT_DIR: s_d.diagnostic_out = s_d.op_dir;
            smsc_pkg::SMSC_DIAGNOSTIC_OUT_STEP: s_d.diagnostic_out = s_d.step_pulse;
            default: s_d.diagnostic_out = s_d.fault;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= smsc_pkg::STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign serial_data_out_o = s_q.serial_data_out;
    assign serial_data_out_oe_n_o = s_q.sdo_oe_n;
    assign diagnostic_out_o = s_q.diagnostic_out;
    assign sleep_o = s_q.sleep;
    assign step_angle_o = s_q.angle;
    assign prdata = s_q.prdata;
    assign pready = psel & penable;
    assign pslverr = psel & penable &
                     (paddr[7:6] != 2'h0 || !reg_mapped(paddr[5:2]));

    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_nsl_frame;
        serial_strobe_n_rise && s_q.rx_cnt == 5'h10 &&
        s_q.rx_sh[15:12] == smsc_pkg::REG_NSL;
    endsequence

    sequence s_short_release;
        rstn_rise && !s_q.sleep && !fault_event_i &&
        s_q.rst_cnt >= 12'h096 && s_q.rst_cnt <= 12'h320;
    endsequence

    AST_SDO_TRISTATE: assert property (
        s_q.sync2.serial_strobe_n && s_q.prev.serial_strobe_n |-> serial_data_out_oe_n_o)
        else $error("serial output driven while strobe high");
    AST_FAULT_FIRST: assert property (
        serial_strobe_n_fall |=> !serial_data_out_oe_n_o &&
                      serial_data_out_o == $past(s_q.fault))
        else $error("fault flag not driven at strobe fall");
    AST_DIAGNOSTIC_OUT_FAULT: assert property (
        s_q.diagnostic_out_sel == smsc_pkg::SMSC_DIAGNOSTIC_OUT_FAULT |->
            diagnostic_out_o == s_q.fault)
        else $error("diagnostic output does not show fault");
    AST_SLEEP_ENTRY: assert property (
        !s_q.sync2.rstn && s_q.rst_cnt == 12'hFA0 |=> sleep_o)
        else $error("sleep not entered after long low");
    AST_SHORT_CLEAR: assert property (
        s_short_release |=> !s_q.fault)
        else $error("short reset pulse did not clear fault");
    AST_LONG_KEEP: assert property (
        rstn_rise && !s_q.sleep && s_q.fault && s_q.rst_cnt > 12'h320
        |=> s_q.fault)
        else $error("over-long reset pulse cleared fault");
    AST_PIN_STEP: assert property (
        step_rise && s_q.seq == smsc_pkg::SMSC_SEQ_IDLE && !s_q.sleep &&
        s_q.mode == smsc_pkg::SMSC_MS_HALF && s_q.sync2.dir &&
        !apb_wr && !serial_strobe_n_rise && !rstn_rise
        |=> step_angle_o == $past(step_angle_o) + 6'h08)
        else $error("pin step did not advance by half step");
    AST_PINS_IGNORED: assert property (
        s_q.seq != smsc_pkg::SMSC_SEQ_IDLE && step_rise && !seq_tick &&
        !apb_wr && !serial_strobe_n_rise && !rstn_rise |=> $stable(step_angle_o))
        else $error("step pin moved motor during sequence");
    AST_SEQ_START: assert property (
        s_nsl_frame ##0 (s_q.rx_sh[7:0] != 8'h00 && !s_q.sleep)
        |=> s_q.seq == smsc_pkg::SMSC_SEQ_CALC ##1
            s_q.seq != smsc_pkg::SMSC_SEQ_IDLE)
        else $error("sequence not started by low count byte");
    AST_DIRECTION_READBACK_LATCH: assert property (
        serial_strobe_n_fall |=> s_q.direction_readback == $past(s_q.op_dir))
        else $error("direction readback not latched");
    AST_COUNT_DOWN: assert property (
        seq_tick && !apb_wr && !serial_strobe_n_rise && !rstn_rise
        |=> s_q.remain == $past(s_q.remain) - 16'h0001)
        else $error("remaining count not reduced by one");
    AST_DECEL: assert property (
        seq_tick && s_q.remain > 16'h0001 &&
        s_q.remain - 16'h0001 <= s_q.dec_steps &&
        !apb_wr && !serial_strobe_n_rise && !rstn_rise
        |=> s_q.rate <= $past(s_q.rate) && s_q.rate >= eff_start)
        else $error("rate rose during deceleration");
endmodule

// ==== verification/smsc_host.sv ====
`timescale 1ns/1ps
module smsc_host (
    output logic sck_o,
    output logic sdi_o,
    output logic serial_strobe_n_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_n_i
);
    // clock idles high, data line shows the inverse of its last bit
    initial begin
        sck_o = 1'b1;
        sdi_o = 1'b0;
        serial_strobe_n_o = 1'b1;
    end
    // one frame; reply bits are sampled just before each clock fall
    task automatic xfer(input logic [15:0] w, output logic [15:0] r,
                        output logic oe);
        serial_strobe_n_o = 1'b0;
        #200;
        for (int i = 15; i >= 0; i--) begin
            r[i] = sdo_i;
            if (i == 15) oe = sdo_oe_n_i;
            sck_o = 1'b0;
            sdi_o = w[i];
            #62.5;
            sck_o = 1'b1;
            #62.5;
        end
        #100;
        serial_strobe_n_o = 1'b1;
        sdi_o = ~w[0];
        #400;
    endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic sck, serial_data_in, serial_strobe_n, serial_data_out, oe_n, diagnostic_out, slp, pready, pslverr, e, oe, s;
    logic step_i = 1'b0;
    logic dir_i = 1'b0;
    logic rsn = 1'b1;
    logic flt = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic [5:0] ang, a;
    logic [15:0] rx;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    // design and host model
    smsc_top dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .serial_clk_i(sck), .serial_data_in_i(serial_data_in),
        .serial_strobe_n_i(serial_strobe_n), .serial_data_out_o(serial_data_out),
        .serial_data_out_oe_n_o(oe_n), .step_i(step_i), .dir_i(dir_i),
        .reset_sleep_n_i(rsn), .fault_event_i(flt),
        .diagnostic_out_o(diagnostic_out), .sleep_o(slp), .step_angle_o(ang),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    smsc_host host_u (.sck_o(sck), .sdi_o(serial_data_in), .serial_strobe_n_o(serial_strobe_n),
        .sdo_i(serial_data_out), .sdo_oe_n_i(oe_n));
    // clock and hang guard
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [3:0] i,
                       input logic [11:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {20'h0, d};
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i != 4'hF) chk(e === 1'b0, "bus error");
    endtask
    task automatic sw(input logic [3:0] i, input logic [11:0] d);
        host_u.xfer({i, d}, rx, oe);
    endtask
    task automatic pstep(input logic d);
        @(posedge ref_clk_i);
        dir_i <= d;
        repeat (5) @(posedge ref_clk_i);
        step_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        step_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
    endtask
    // low pulse on the reset pin; sleep state seen just before release
    task automatic rpin(input int n);
        @(posedge ref_clk_i);
        rsn <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
        s = slp;
        rsn <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
    endtask
    task automatic t_reset();
        apb(1'b0, smsc_pkg::REG_CFG, 12'h0);
        chk(r[4:0] === 5'h01, "cfg reset");
        apb(1'b1, smsc_pkg::REG_STAT, 12'hFFF);
        apb(1'b0, smsc_pkg::REG_STAT, 12'h0);
        chk(r[8:0] === 9'h008, "status reset");
        apb(1'b0, 4'hF, 12'h0);
        chk(e === 1'b1 && r === 32'h0, "unmapped");
        chk(oe_n === 1'b1 && diagnostic_out === 1'b0, "idle out");
    endtask
    task automatic t_fault();
        int len[2] = '{100, 300};
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk_i);
            flt <= 1'b1;
            @(posedge ref_clk_i);
            flt <= 1'b0;
            repeat (3) @(posedge ref_clk_i);
            chk(diagnostic_out === 1'b1, "fault out");
            sw(smsc_pkg::REG_ACC, 12'h001);
            chk(oe === 1'b0 && rx[15] === 1'b1, "fault first");
            rpin(len[k]);
            chk(diagnostic_out === (k == 0) && s === 1'b0, "pulse");
        end
    endtask
    task automatic t_pins();
        logic [5:0] x;
        pstep(1'b0);
        chk(ang === 6'h00, "half down");
        x = 6'h00;
        for (int m = 0; m < 6; m++) begin
            sw(smsc_pkg::REG_CFG, 12'(m));
            pstep(1'b1);
            x = x + ((m == 5) ? 6'h10 : 6'(16 >> m));
            chk(ang === x, "mode step");
        end
        sw(smsc_pkg::REG_STEP, 12'h038);
        chk(ang === x - 6'h08, "back eight");
        sw(smsc_pkg::REG_STEP, 12'h010);
        chk(ang === x + 6'h08, "fwd sixteen");
    endtask
    task automatic t_seq();
        logic [11:0] v[7] = '{12'h1, 12'h1, 12'h1, 12'h2, 12'h0, 12'h0,
                              12'h20};
        for (int k = 0; k < 7; k++) sw(4'(k + 2), v[k]);
        apb(1'b0, smsc_pkg::REG_STAT, 12'h0);
        chk(r[8:7] === 2'b01, "running");
        a = ang;
        pstep(1'b1);
        chk(ang === a, "pins ignored");
        sw(smsc_pkg::REG_ACC, 12'h003);
        apb(1'b0, smsc_pkg::REG_DIRECTION_READBACK, 12'h0);
        chk(r[0] === 1'b0, "dir readback");
        rpin(4100);
        chk(s === 1'b1 && slp === 1'b0, "sleep");
        chk(ang === 6'h00, "home");
        apb(1'b0, smsc_pkg::REG_STAT, 12'h0);
        chk(r[7] === 1'b0, "stopped");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        t_reset();
        t_fault();
        t_pins();
        t_seq();
        results();
    end
endmodule
